// ===== src/hbus_pkg.sv
// Shared constants, enumerations and carriers for the host bus port.
// Assumes a single sequencer clock and an asynchronous active-high reset.
package hbus_pkg;

  // ==========================================================
  // Address and data widths
  localparam int ADDR_W = 18;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int UADDR_W = 10;
  localparam int BASE_W = 11;

  // ==========================================================
  // Address decode
  localparam logic [17:0] IO_PAGE_BASE = 18'h3E000;
  localparam logic [17:0] BOOT_ADDR_A = 18'h3F600;
  localparam logic [17:0] BOOT_ADDR_B = 18'h3F800;
  localparam logic [17:0] BOOT_ADDR_C = 18'h3F200;
  localparam int IO_PAGE_LSB = 13;
  localparam int BASE_LSB = 2;
  localparam int BASE_MSB = 12;
  localparam int REG_SEL_BIT = 1;
  localparam int BOOT_LSB = 9;

  // Boot option switch codes: one of three, or none.
  localparam logic [1:0] BOOT_NONE = 2'h0;
  localparam logic [1:0] BOOT_SEL_A = 2'h1;
  localparam logic [1:0] BOOT_SEL_B = 2'h2;
  localparam logic [1:0] BOOT_SEL_C = 2'h3;

  // ==========================================================
  // Routine start addresses placed on the next-address bus
  localparam logic [9:0] RT_FETCH = 10'h000;
  localparam logic [9:0] RT_REG_IP = 10'h040;
  localparam logic [9:0] RT_REG_SA = 10'h048;
  localparam logic [9:0] RT_BOOT_A = 10'h080;
  localparam logic [9:0] RT_BOOT_B = 10'h088;
  localparam logic [9:0] RT_BOOT_C = 10'h090;
  localparam logic [9:0] RT_VECTOR = 10'h0C0;
  localparam logic [9:0] RT_DMA = 10'h100;
  localparam logic [9:0] UADDR_ONE = 10'h001;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 40;
  localparam int TIMEOUT_NS = 10000;
  localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_NS;
  localparam logic [8:0] TIMEOUT_LAST = 9'(TIMEOUT_CYC - 1);

  // ==========================================================
  // Master-side state
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_ADDR = 3'b001,
    M_DRIVE = 3'b011,
    M_SYNC = 3'b010,
    M_DONE = 3'b110
  } mstate_t;

  // Three-byte DMA address load steps.
  typedef enum logic [1:0] {
    LD_LOW = 2'h0,
    LD_MID = 2'h1,
    LD_HIGH = 2'h2
  } ld_step_t;

  // Synchronised request conditions as seen by the dispatch table.
  typedef struct packed {
    logic io_window_hit;
    logic base_match;
    logic addr_strobe;
    logic register_select_bit;
    logic [2:0] boot_hit;
    logic irq_grant_flag;
    logic dma_grant_flag;
  } req_cond_t;

  // Microword control strobes from the sequencer.
  typedef struct packed {
    logic dma_addr_load_low;
    logic dma_addr_load_mid;
    logic dma_addr_load_high;
    logic address_drive_enable;
    logic master_sync_drive;
    logic inbound_data_enable;
    logic outbound_load_low;
    logic outbound_load_high;
    logic outbound_word_load;
    logic outbound_data_drive;
    logic irq_request;
    logic dma_request;
    logic intr_drive;
    logic end_of_routine;
  } ustrobe_t;

endpackage

// ===== src/host_bus_port.sv
// Host bus slave decode and master port of the disc controller board.
// Assumes bus transceivers outside; inputs are synchronous to mclk_i.
`timescale 1ns/1ps
// Behaviour
// [RULE1] Eighteen-bit addresses latched and driven bidirectionally
// [RULE2] Flag I/O page and three boot addresses
// [RULE3] Bits 2..12 matched against base switch
// [RULE4] Window, match, strobe synchronised; all start routine
// [RULE5] Address bit 1 selects register
// [RULE6] One boot option; strobe and bit1 start
// [RULE7] DMA address loaded low, mid, high bytes
// [RULE8] High load also captures read/write control
// [RULE9] One enable drives address and control
// [RULE10] Master sync asserted after address driven
// [RULE11] Inbound data gated to word bus
// [RULE12] Outbound load by byte or word, separate drive
// [RULE13] Level 5 request held until grant
// [RULE14] Grant flagged, synchronised, vector routine starts
// [RULE15] Vector driven with interrupt line
// [RULE16] Non-processor request starts DMA
// [RULE17] Grant latched, synchronised, DMA routine starts
// [RULE18] Selection acknowledge before any data transfer
// [RULE19] Dispatch start, then next-step table
// [RULE20] End-of-routine returns control to dispatch
// [RULE21] Idle sequencer runs instruction fetch
// [RULE22] Slave supports data in, out, read-modify-write
// [RULE23] Detect parity and timeout during DMA
// [RULE24] All three loads before transfer start
module host_bus_port
  import hbus_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Host bus, slave side
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic bus_msyn_i,
  input wire logic bus_c1_i,
  input wire logic [BASE_W-1:0] base_switch_i,
  input wire logic [1:0] boot_switch_i,
  // Host bus, master side (enable low while driving)
  output logic [ADDR_W-1:0] bus_addr_o,
  output logic bus_c1_o,
  output logic bus_addr_oe_n_o,
  output logic bus_msyn_o,
  input wire logic bus_ssyn_i,
  input wire logic bus_parity_err_i,
  input wire logic [WORD_W-1:0] bus_data_i,
  output logic [WORD_W-1:0] bus_data_o,
  output logic bus_data_oe_n_o,
  output logic bus_br5_o,
  input wire logic bus_bg5_i,
  output logic bus_intr_o,
  output logic bus_npr_o,
  input wire logic bus_npg_i,
  output logic bus_sack_o,
  // Sequencer side
  input wire ustrobe_t ustrobe_i,
  input wire logic [UADDR_W-1:0] next_step_i,
  input wire logic [BYTE_W-1:0] internal_byte_bus_i,
  input wire logic [WORD_W-1:0] cache_word_i,
  output logic [UADDR_W-1:0] next_addr_o,
  output logic dispatch_active_o,
  output logic [WORD_W-1:0] internal_word_bus_o,
  output logic [BYTE_W-1:0] internal_byte_bus_o,
  output logic slave_cycle_write_o,
  output logic dma_addr_ready_o,
  output logic dma_parity_err_o,
  output logic dma_timeout_err_o
);

  // ==========================================================
  // Address latch and decode
  logic [ADDR_W-1:0] latched_address_lines_q;
  logic latched_c1_q;
  logic strobe_q;
  logic io_window_hit;
  logic base_match;
  logic [2:0] boot_hit;
  logic [2:0] boot_enable;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      latched_address_lines_q <= '0;
      latched_c1_q <= 1'b0;
      strobe_q <= 1'b0;
    end
    else
    begin
      // The strobe is delayed with the latch, so a fresh strobe never meets a stale decode.
      strobe_q <= bus_msyn_i;
      if (bus_msyn_i)
      begin
        latched_address_lines_q <= bus_addr_i; // [RULE1]
        latched_c1_q <= bus_c1_i;
      end
    end
  end

  assign io_window_hit = (latched_address_lines_q & IO_PAGE_BASE) == IO_PAGE_BASE; // [RULE2]
  assign base_match = latched_address_lines_q[BASE_MSB:BASE_LSB] == base_switch_i; // [RULE3]
  assign boot_enable = {boot_switch_i == BOOT_SEL_C, boot_switch_i == BOOT_SEL_B,
                        boot_switch_i == BOOT_SEL_A}; // [RULE6]

  // The low boot address bits are not compared here; address bit 1 must still be set for a boot start.
  genvar gi;
  for (gi = 0; gi < 3; gi++)
  begin : g_boot
    localparam logic [17:0] BOOT_TAB = (gi == 0) ? BOOT_ADDR_A : ((gi == 1) ? BOOT_ADDR_B : BOOT_ADDR_C);
    assign boot_hit[gi] = boot_enable[gi] &&
      (latched_address_lines_q[ADDR_W-1:BOOT_LSB] == BOOT_TAB[ADDR_W-1:BOOT_LSB]); // [RULE2]
  end

  // ==========================================================
  // Synchronising registers feeding the dispatch table
  req_cond_t cond_q;
  logic irq_grant_flag_q;
  logic dma_grant_flag_q;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cond_q <= '0;
    end
    else
    begin
      cond_q.io_window_hit <= io_window_hit; // [RULE4]
      cond_q.base_match <= base_match;
      cond_q.addr_strobe <= strobe_q; // [RULE4]
      cond_q.register_select_bit <= latched_address_lines_q[REG_SEL_BIT]; // [RULE5]
      cond_q.boot_hit <= boot_hit;
      cond_q.irq_grant_flag <= irq_grant_flag_q; // [RULE14]
      cond_q.dma_grant_flag <= dma_grant_flag_q; // [RULE17]
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      slave_cycle_write_o <= 1'b0;
    end
    else
    begin
      // C1 high marks a data-out; a read-modify-write reads first then writes.
      slave_cycle_write_o <= latched_c1_q; // [RULE22]
    end
  end

  // ==========================================================
  // Sequencer next-address selection
  logic [UADDR_W-1:0] disp_start;
  logic disp_pending;
  logic trap_q;

  routine_dispatch_table u_dispatch (
    .cond_i(cond_q),
    .start_o(disp_start),
    .pending_o(disp_pending)
  );

  assign next_addr_o = trap_q ? disp_start : next_step_i; // [RULE19]
  assign dispatch_active_o = trap_q;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      trap_q <= 1'b1; // [RULE21]
    end
    else if (trap_q)
    begin
      trap_q <= 1'b0; // [RULE19]
    end
    else if (ustrobe_i.end_of_routine)
    begin
      trap_q <= 1'b1; // [RULE20]
    end
  end

  // ==========================================================
  // Bus requests and grant flags
  // A grant that lands while the flag is being consumed wins over the clear.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bus_br5_o <= 1'b0;
      irq_grant_flag_q <= 1'b0;
    end
    else
    begin
      if (bus_bg5_i && bus_br5_o)
      begin
        irq_grant_flag_q <= 1'b1; // [RULE14]
        bus_br5_o <= 1'b0;
      end
      else
      begin
        if (ustrobe_i.irq_request)
        begin
          bus_br5_o <= 1'b1; // [RULE13]
        end
        if (trap_q && disp_start == RT_VECTOR)
        begin
          irq_grant_flag_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bus_npr_o <= 1'b0;
      dma_grant_flag_q <= 1'b0;
      bus_sack_o <= 1'b0;
    end
    else
    begin
      if (bus_npg_i && bus_npr_o)
      begin
        dma_grant_flag_q <= 1'b1; // [RULE17]
        bus_npr_o <= 1'b0;
      end
      else
      begin
        if (ustrobe_i.dma_request)
        begin
          bus_npr_o <= 1'b1; // [RULE16]
        end
        if (trap_q && disp_start == RT_DMA)
        begin
          dma_grant_flag_q <= 1'b0;
        end
      end
      if (trap_q && disp_start == RT_DMA)
      begin
        bus_sack_o <= 1'b1; // [RULE18]
      end
      else if (ustrobe_i.end_of_routine)
      begin
        bus_sack_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // DMA address transceivers and master cycle
  logic [2:0] ld_done_q;
  mstate_t mstate_q;
  logic [8:0] tmo_cnt_q;

  assign dma_addr_ready_o = &ld_done_q; // [RULE24]

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bus_addr_o <= '0;
      bus_c1_o <= 1'b0;
      ld_done_q <= '0;
    end
    else
    begin
      if (ustrobe_i.dma_addr_load_low)
      begin
        bus_addr_o[7:0] <= internal_byte_bus_i; // [RULE7]
        ld_done_q[LD_LOW] <= 1'b1;
      end
      if (ustrobe_i.dma_addr_load_mid)
      begin
        bus_addr_o[15:8] <= internal_byte_bus_i; // [RULE7]
        ld_done_q[LD_MID] <= 1'b1;
      end
      if (ustrobe_i.dma_addr_load_high)
      begin
        bus_addr_o[17:16] <= internal_byte_bus_i[1:0]; // [RULE7] [RULE24]
        bus_c1_o <= internal_byte_bus_i[BYTE_W-1]; // [RULE8]
        ld_done_q[LD_HIGH] <= 1'b1;
      end
      if (mstate_q == M_DONE)
      begin
        ld_done_q <= '0; // [RULE24]
      end
    end
  end

  // Driving only starts once every byte is loaded, so a stale high byte never
  // reaches the bus.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mstate_q <= M_IDLE;
      tmo_cnt_q <= '0;
      dma_parity_err_o <= 1'b0;
      dma_timeout_err_o <= 1'b0;
    end
    else
    begin
      case (mstate_q)
        M_IDLE:
        begin
          if (ustrobe_i.address_drive_enable && dma_addr_ready_o && bus_sack_o)
          begin
            mstate_q <= M_DRIVE; // [RULE9] [RULE18] [RULE24]
          end
        end
        M_DRIVE:
        begin
          if (ustrobe_i.master_sync_drive)
          begin
            mstate_q <= M_SYNC; // [RULE10]
            tmo_cnt_q <= '0;
          end
        end
        M_SYNC:
        begin
          if (bus_ssyn_i)
          begin
            dma_parity_err_o <= bus_parity_err_i; // [RULE23]
            mstate_q <= M_DONE;
          end
          else if (tmo_cnt_q == TIMEOUT_LAST)
          begin
            dma_timeout_err_o <= 1'b1; // [RULE23]
            mstate_q <= M_DONE;
          end
          else
          begin
            tmo_cnt_q <= tmo_cnt_q + 9'h001;
          end
        end
        M_DONE:
        begin
          if (!ustrobe_i.master_sync_drive)
          begin
            mstate_q <= M_IDLE;
          end
        end
        default:
        begin
          mstate_q <= M_IDLE;
        end
      endcase
      if (mstate_q == M_IDLE && ustrobe_i.dma_request)
      begin
        dma_parity_err_o <= 1'b0;
        dma_timeout_err_o <= 1'b0;
      end
    end
  end

  assign bus_addr_oe_n_o = !(mstate_q == M_DRIVE || mstate_q == M_SYNC || mstate_q == M_DONE); // [RULE9]
  assign bus_msyn_o = (mstate_q == M_SYNC); // [RULE10]

  // ==========================================================
  // Data transceivers
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      internal_word_bus_o <= '0;
      internal_byte_bus_o <= '0;
      bus_data_o <= '0;
    end
    else
    begin
      if (ustrobe_i.inbound_data_enable)
      begin
        internal_word_bus_o <= bus_data_i; // [RULE11]
        internal_byte_bus_o <= latched_address_lines_q[0] ? bus_data_i[15:8] : bus_data_i[7:0];
      end
      if (ustrobe_i.outbound_word_load)
      begin
        bus_data_o <= cache_word_i; // [RULE12]
      end
      else
      begin
        if (ustrobe_i.outbound_load_low)
        begin
          bus_data_o[7:0] <= internal_byte_bus_i; // [RULE12] [RULE15]
        end
        if (ustrobe_i.outbound_load_high)
        begin
          bus_data_o[15:8] <= internal_byte_bus_i; // [RULE12] [RULE15]
        end
      end
    end
  end

  assign bus_data_oe_n_o = !ustrobe_i.outbound_data_drive; // [RULE12]
  assign bus_intr_o = ustrobe_i.intr_drive && ustrobe_i.outbound_data_drive; // [RULE15]

endmodule

// ===== src/routine_dispatch_table.sv
// Routine dispatch table: maps synchronised conditions to a routine start.
// Assumes its inputs are already registered in the sequencer clock domain.
`timescale 1ns/1ps
module routine_dispatch_table
  import hbus_pkg::*;
(
  input wire req_cond_t cond_i,
  output logic [UADDR_W-1:0] start_o,
  output logic pending_o
);

  // ==========================================================
  // Priority: grants, then register access, then boot, then fetch.
  always_comb
  begin
    pending_o = 1'b1;
    start_o = RT_FETCH;
    if (cond_i.irq_grant_flag)
    begin
      start_o = RT_VECTOR; // [RULE14]
    end
    else if (cond_i.dma_grant_flag)
    begin
      start_o = RT_DMA; // [RULE17]
    end
    else if (cond_i.io_window_hit && cond_i.base_match && cond_i.addr_strobe)
    begin
      start_o = cond_i.register_select_bit ? RT_REG_SA : RT_REG_IP; // [RULE4] [RULE5]
    end
    else if (cond_i.addr_strobe && cond_i.register_select_bit && (|cond_i.boot_hit))
    begin
      start_o = cond_i.boot_hit[0] ? RT_BOOT_A : (cond_i.boot_hit[1] ? RT_BOOT_B : RT_BOOT_C); // [RULE6]
    end
    else
    begin
      pending_o = 1'b0;
      start_o = RT_FETCH; // [RULE21]
    end
  end

endmodule

// ===== test/host_bus_model.sv
// Host side of the backplane: grants bus requests and answers master cycles.
// Assumes the port's request and sync lines are registered on mclk_i.
`timescale 1ns/1ps
module host_bus_model
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic br5_i,
  input wire logic npr_i,
  input wire logic msyn_i,
  input wire logic stall_i,
  input wire logic perr_i,
  input wire logic [15:0] word_i,
  output logic bg5_o,
  output logic npg_o,
  output logic ssyn_o,
  output logic perr_o,
  output logic [15:0] data_o
);
  // ==========================================================
  // Grants and slave reply
  logic [15:0] last_q;

  // A stalled host holds grants and replies back, which also provokes the timeout.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      bg5_o <= 1'h0;
      npg_o <= 1'h0;
      ssyn_o <= 1'h0;
    end
    else
    begin
      bg5_o <= br5_i && !stall_i;
      npg_o <= npr_i && !stall_i;
      ssyn_o <= msyn_i && !stall_i;
    end

  // Outside a reply the data lines toggle, so stale data never looks valid.
  always_ff @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
      last_q <= '0;
    else
      last_q <= data_o;
  assign data_o = ssyn_o ? word_i : ~last_q;
  assign perr_o = ssyn_o && perr_i;
endmodule

// ===== test/host_bus_port_asserts.sv
// Concurrent checks on the host bus port, attached by bind.
// Assumes one clock, mclk_i, and the asynchronous active-high sys_rst_i.
`timescale 1ns/1ps
module host_bus_port_asserts
  import hbus_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic bus_msyn_i,
  input wire logic [BYTE_W-1:0] internal_byte_bus_i,
  input wire logic [WORD_W-1:0] bus_data_i,
  input wire ustrobe_t ustrobe_i,
  input wire logic [UADDR_W-1:0] next_step_i,
  input wire logic bus_bg5_i,
  input wire logic bus_c1_o,
  input wire logic bus_addr_oe_n_o,
  input wire logic bus_msyn_o,
  input wire logic bus_data_oe_n_o,
  input wire logic bus_br5_o,
  input wire logic bus_intr_o,
  input wire logic bus_sack_o,
  input wire logic [UADDR_W-1:0] next_addr_o,
  input wire logic dispatch_active_o,
  input wire logic [WORD_W-1:0] internal_word_bus_o,
  input wire logic dma_addr_ready_o
);
  // ==========================================================
  // Properties
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic reg_hit;
  logic c1_in;
  assign reg_hit = dispatch_active_o && (next_addr_o == RT_REG_IP || next_addr_o == RT_REG_SA);
  assign c1_in = internal_byte_bus_i[7];

  a_reg_needs_strobe: assert property (reg_hit |-> $past(bus_msyn_i) || $past(bus_msyn_i, 2))
    else $error("register routine without address strobe");
  a_step_after_trap: assert property (!dispatch_active_o |-> next_addr_o == next_step_i)
    else $error("next address not from next-step table");
  a_trap_one_cycle: assert property (dispatch_active_o && next_addr_o != RT_FETCH |=> !dispatch_active_o)
    else $error("dispatch held past one cycle");
  a_eor_returns: assert property (ustrobe_i.end_of_routine |=> dispatch_active_o)
    else $error("end of routine did not return dispatch");
  a_br5_held: assert property (bus_br5_o && !bus_bg5_i |=> bus_br5_o)
    else $error("level 5 request dropped before grant");
  a_msyn_after_drive: assert property ($rose(bus_msyn_o) |-> !$past(bus_addr_oe_n_o) && bus_sack_o)
    else $error("master sync before address driven");
  a_drive_needs_all: assert property ($fell(bus_addr_oe_n_o) |-> $past(dma_addr_ready_o) && bus_sack_o)
    else $error("address driven before all loads");
  a_c1_on_high: assert property (ustrobe_i.dma_addr_load_high |=> bus_c1_o == $past(c1_in))
    else $error("control bit not captured");
  a_word_bus_load: assert property (ustrobe_i.inbound_data_enable |=> internal_word_bus_o == $past(bus_data_i))
    else $error("inbound word not gated");
  a_intr_with_data: assert property (bus_intr_o |-> !bus_data_oe_n_o)
    else $error("interrupt line without vector drive");

  c_reg: cover property (reg_hit);
  c_sync: cover property ($rose(bus_msyn_o));
  c_intr: cover property (bus_intr_o);
endmodule

bind host_bus_port host_bus_port_asserts i_chk (.mclk_i, .sys_rst_i, .bus_msyn_i, .internal_byte_bus_i, .bus_data_i,
  .ustrobe_i, .next_step_i, .bus_bg5_i, .bus_c1_o, .bus_addr_oe_n_o, .bus_msyn_o, .bus_data_oe_n_o, .bus_br5_o,
  .bus_intr_o, .bus_sack_o, .next_addr_o, .dispatch_active_o, .internal_word_bus_o, .dma_addr_ready_o);

// ===== test/tb_host_bus_port.sv
// Self-checking bench for the host bus port, with the host model beside it.
// Assumes the package and port under src/ and the model under test/.
`timescale 1ns/1ps
module tb_host_bus_port
  import hbus_pkg::*;
;
  logic mclk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic bus_msyn_i = 1'h0, bus_c1_i = 1'h0, stall = 1'h0, perr = 1'h0;
  logic [ADDR_W-1:0] bus_addr_i = '0, bus_addr_o;
  logic [BASE_W-1:0] base_switch_i = 11'h100;
  logic [1:0] boot_switch_i = BOOT_NONE;
  ustrobe_t ustrobe_i = '0;
  logic [UADDR_W-1:0] next_step_i = 10'h155, next_addr_o;
  logic [BYTE_W-1:0] internal_byte_bus_i = '0;
  logic [WORD_W-1:0] cache_word_i = '0, bus_data_i, bus_data_o, internal_word_bus_o;
  logic [BYTE_W-1:0] internal_byte_bus_o;
  logic bus_c1_o, bus_addr_oe_n_o, bus_msyn_o, bus_ssyn_i, bus_parity_err_i, bus_data_oe_n_o, bus_br5_o, bus_bg5_i;
  logic bus_intr_o, bus_npr_o, bus_npg_i, bus_sack_o, dispatch_active_o, slave_cycle_write_o;
  logic dma_addr_ready_o, dma_parity_err_o, dma_timeout_err_o;
  int n_errors = 0;
  int checks = 0;

  host_bus_port i_dut (.mclk_i, .sys_rst_i, .bus_addr_i, .bus_msyn_i, .bus_c1_i, .base_switch_i, .boot_switch_i,
    .bus_addr_o, .bus_c1_o, .bus_addr_oe_n_o, .bus_msyn_o, .bus_ssyn_i, .bus_parity_err_i, .bus_data_i,
    .bus_data_o, .bus_data_oe_n_o, .bus_br5_o, .bus_bg5_i, .bus_intr_o, .bus_npr_o, .bus_npg_i, .bus_sack_o,
    .ustrobe_i, .next_step_i, .internal_byte_bus_i, .cache_word_i, .next_addr_o, .dispatch_active_o,
    .internal_word_bus_o, .internal_byte_bus_o, .slave_cycle_write_o, .dma_addr_ready_o, .dma_parity_err_o,
    .dma_timeout_err_o);
  host_bus_model i_host (.mclk_i, .sys_rst_i, .br5_i(bus_br5_o), .npr_i(bus_npr_o), .msyn_i(bus_msyn_o),
    .stall_i(stall), .perr_i(perr), .word_i(16'hBEEF), .bg5_o(bus_bg5_i), .npg_o(bus_npg_i), .ssyn_o(bus_ssyn_i),
    .perr_o(bus_parity_err_i), .data_o(bus_data_i));

  initial
  begin
    forever #20 mclk_i = ~mclk_i;
  end

  // ==========================================================
  // Common tasks
  task automatic step(input int n = 1);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic conclude();
    $display("Mismatches %0d, comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp({17'h0, got}, {17'h0, exp});
  endtask

  task automatic pulse(input ustrobe_t s);
    ustrobe_i = s;
    step();
    ustrobe_i = '0;
    step();
  endtask

  task automatic ld(input ustrobe_t s, input logic [7:0] b);
    internal_byte_bus_i = b;
    pulse(s);
  endtask

  // The trap lasts one cycle, so every cycle is sampled while waiting.
  task automatic wait_trap(input logic [9:0] exp);
    int i = 0;
    // The running fetch routine ends whenever the trap is down, so dispatch gets a look.
    while (!(dispatch_active_o === 1'h1 && next_addr_o !== RT_FETCH) && i < 20)
    begin
      ustrobe_i.end_of_routine = !dispatch_active_o;
      step();
      i++;
    end
    ustrobe_i.end_of_routine = 1'h0;
    if (i == 20)
    begin
      n_errors++;
      $display("Error at %0t: no dispatch", $time);
      conclude();
    end
    cmp(18'(next_addr_o), 18'(exp));
  endtask

  task automatic finish_rt();
    bus_msyn_i = 1'h0;
    step(3);
    ustrobe_i = ustrobe_t'{end_of_routine: 1'h1, default: 1'h0};
    step();
    ustrobe_i = '0;
    cmp1(dispatch_active_o, 1'h1);
    cmp(18'(next_addr_o), 18'(RT_FETCH));
    step();
  endtask

  task automatic refused(input logic [17:0] a);
    bus_addr_i = a;
    bus_msyn_i = 1'h1;
    step(3);
    ustrobe_i = ustrobe_t'{end_of_routine: 1'h1, default: 1'h0};
    step();
    ustrobe_i = '0;
    cmp1(dispatch_active_o, 1'h1);
    cmp(18'(next_addr_o), 18'(RT_FETCH));
    bus_msyn_i = 1'h0;
    step(3);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_slave();
    for (int k = 0; k < 2; k++)
    begin
      bus_addr_i = IO_PAGE_BASE | {5'h0, base_switch_i, 2'h0} | (18'(k) << 1);
      bus_c1_i = k[0];
      bus_msyn_i = 1'h1;
      wait_trap(k ? RT_REG_SA : RT_REG_IP);
      cmp1(slave_cycle_write_o, k[0]);
      finish_rt();
    end
    refused({5'h0, base_switch_i, 2'h0});
    refused(IO_PAGE_BASE | {5'h0, ~base_switch_i, 2'h0});
  endtask

  task automatic t_boot();
    logic [17:0] ba[3] = '{BOOT_ADDR_A, BOOT_ADDR_B, BOOT_ADDR_C};
    logic [9:0] rt[3] = '{RT_BOOT_A, RT_BOOT_B, RT_BOOT_C};
    for (int k = 0; k < 3; k++)
    begin
      boot_switch_i = 2'(k + 1);
      bus_addr_i = ba[k] | 18'h2;
      bus_msyn_i = 1'h1;
      wait_trap(rt[k]);
      finish_rt();
    end
    refused(BOOT_ADDR_A | 18'h2);
    boot_switch_i = BOOT_NONE;
  endtask

  task automatic t_irq();
    stall = 1'h1;
    pulse(ustrobe_t'{irq_request: 1'h1, default: 1'h0});
    step(3);
    cmp1(bus_br5_o, 1'h1);
    stall = 1'h0;
    wait_trap(RT_VECTOR);
    cmp1(bus_br5_o, 1'h0);
    cache_word_i = 16'h00A4;
    pulse(ustrobe_t'{outbound_word_load: 1'h1, default: 1'h0});
    ustrobe_i = ustrobe_t'{outbound_data_drive: 1'h1, intr_drive: 1'h1, default: 1'h0};
    step();
    cmp(18'(bus_data_o), 18'h000A4);
    cmp1(bus_intr_o, 1'h1);
    cmp1(bus_data_oe_n_o, 1'h0);
    ustrobe_i = '0;
    step();
    cmp1(bus_data_oe_n_o, 1'h1);
    ld(ustrobe_t'{outbound_load_low: 1'h1, default: 1'h0}, 8'h5A);
    ld(ustrobe_t'{outbound_load_high: 1'h1, default: 1'h0}, 8'hC3);
    cmp(18'(bus_data_o), 18'h0C35A);
    finish_rt();
  endtask

  // Loads the address high byte first, since any order is allowed.
  task automatic master_cycle();
    ld(ustrobe_t'{dma_addr_load_high: 1'h1, default: 1'h0}, 8'h82);
    ld(ustrobe_t'{dma_addr_load_mid: 1'h1, default: 1'h0}, 8'hA5);
    cmp1(dma_addr_ready_o, 1'h0);
    ld(ustrobe_t'{dma_addr_load_low: 1'h1, default: 1'h0}, 8'hC3);
    cmp1(dma_addr_ready_o, 1'h1);
    cmp(bus_addr_o, 18'h2A5C3);
    cmp1(bus_c1_o, 1'h1);
    pulse(ustrobe_t'{address_drive_enable: 1'h1, default: 1'h0});
    cmp1(bus_addr_oe_n_o, 1'h0);
    ustrobe_i = ustrobe_t'{master_sync_drive: 1'h1, default: 1'h0};
    step();
    cmp1(bus_msyn_o, 1'h1);
  endtask

  task automatic t_dma();
    int i;
    stall = 1'h1;
    pulse(ustrobe_t'{dma_request: 1'h1, default: 1'h0});
    cmp1(bus_npr_o, 1'h1);
    stall = 1'h0;
    wait_trap(RT_DMA);
    step();
    cmp1(bus_sack_o, 1'h1);
    master_cycle();
    step();
    perr = 1'h1;
    ustrobe_i = ustrobe_t'{master_sync_drive: 1'h1, inbound_data_enable: 1'h1, default: 1'h0};
    step();
    cmp(18'(internal_word_bus_o), 18'h0BEEF);
    cmp(18'(internal_byte_bus_o), 18'h000EF);
    ustrobe_i = '0;
    perr = 1'h0;
    step(2);
    cmp1(dma_parity_err_o, 1'h1);
    cmp1(bus_addr_oe_n_o, 1'h1);
    cmp1(dma_addr_ready_o, 1'h0);
    stall = 1'h1;
    master_cycle();
    for (i = 0; i < 300 && dma_timeout_err_o !== 1'h1; i++)
      step();
    cmp1(dma_timeout_err_o, 1'h1);
    cmp1(i > TIMEOUT_CYC - 5, 1'h1);
    ustrobe_i = '0;
    stall = 1'h0;
    step(2);
    finish_rt();
    cmp1(bus_sack_o, 1'h0);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    step(19);
    cmp1(dispatch_active_o, 1'h1);
    cmp(18'(next_addr_o), 18'(RT_FETCH));
    cmp1(bus_addr_oe_n_o, 1'h1);
    step();
    sys_rst_i = 1'h0;
    step(2);
    t_slave();
    t_boot();
    t_irq();
    t_dma();
    conclude();
  end
endmodule
